// ===== inc/plhf_cfg.svh
// register offsets, field positions, reset values and timing for the loop c control block
`ifndef PLHF_CFG_SVH
`define PLHF_CFG_SVH

// ==========================================
// register offsets
`define PLHF_OFS_STEP_MASK   16'h0622
`define PLHF_OFS_STEP_WORD   16'h0623
`define PLHF_STEP_BYTES      7
`define PLHF_OFS_INPUT_SEL   16'h062a
`define PLHF_OFS_FASTLOCK    16'h062b
`define PLHF_OFS_HOLDOVER    16'h062c
`define PLHF_OFS_HIST_LEN    16'h062e
`define PLHF_OFS_HIST_DLY    16'h062f

// ==========================================
// field positions
`define PLHF_FL_AUTO_BIT     0
`define PLHF_FL_FORCE_BIT    1
`define PLHF_HO_EN_BIT       0
`define PLHF_HO_BYP_BIT      3
`define PLHF_HO_EXIT_BIT     4
`define PLHF_HO_RATE_LSB     5
`define PLHF_SEL_MAX_CODE    3'h3

// ==========================================
// reset values
`define PLHF_RST_INPUT_SEL   3'h0
`define PLHF_RST_AUTO        1'b0
`define PLHF_RST_FORCE       1'b0
`define PLHF_RST_HO_EN       1'b1
`define PLHF_RST_BYP         1'b0
`define PLHF_RST_EXIT        1'b0
`define PLHF_RST_RATE        3'h0
`define PLHF_RST_HIST        5'h00
`define PLHF_RST_MASK        1'b0

// ==========================================
// base ramp rates in units of 0.01 ppm/s
`define PLHF_RATE_0          12'h094
`define PLHF_RATE_1          12'h0de
`define PLHF_RATE_2          12'h0fd
`define PLHF_RATE_3          12'h076
`define PLHF_RATE_4          12'h04a
`define PLHF_RATE_5          12'h1fa
`define PLHF_RATE_6          12'h3f4
`define PLHF_RATE_7          12'hfd0

// ==========================================
// timing: delay unit 2/3 x 100 ns, window unit 8/3 x 100 ns
`define PLHF_CLK_PS          25000
`define PLHF_UNIT_PS         100000
`define PLHF_WIN_NUM         8
`define PLHF_DLY_NUM         2
`define PLHF_UNIT_DEN        3
`define PLHF_DLY_PHASE_TOP   (`PLHF_DLY_NUM * `PLHF_UNIT_PS)
`define PLHF_DLY_PHASE_STEP  (`PLHF_UNIT_DEN * `PLHF_CLK_PS)
`define PLHF_WIN_PER_DLY     (`PLHF_WIN_NUM / `PLHF_DLY_NUM)

`endif

// ===== inc/plhf_pkg.sv
// types shared by the loop c control block
package plhf_pkg;

    // ==========================================
    // bandwidth state, gray along normal -> fast -> holdover
    typedef enum logic [1:0] {
        PLHF_NORMAL = 2'h0,
        PLHF_FAST   = 2'h1,
        PLHF_HOLD   = 2'h3
    } plhf_state_e;

    // ==========================================
    // loop steering bundle
    typedef struct packed {
        logic       fast_bw;
        logic       holdover;
        logic       input_valid;
        logic [1:0] input_sel;
    } plhf_loop_s;

    // ==========================================
    // pins that cross into the clock domain
    typedef struct packed {
        logic       hold_req;
        logic       inc_req;
        logic       dec_req;
        logic       loss_of_lock_flag;
        logic       regctrl;
        logic [1:0] sel_pins;
    } plhf_pins_s;

endpackage

// ===== design/plhf_ctrl.sv
// loop c control: input choice, fastlock, holdover history, ramp rate and dco stepping
//
// Behaviour
// R1: 3-bit choice picks inputs 0-3, default 0
// R2: flag low: pins select input, register ignored
// R3: fastlock bit 0 enables auto fastlock, default off
// R4: fastlock bit 1 forces fastlock, default off
// R5: fastlock active selects wide fastlock bandwidth
// R6: auto fastlock reverts once loss of lock clears
// R7: holdover bit 0 enables holdover, default on
// R8: software writes ramp bypass 1 for operation
// R9: holdover bit 4 picks exit bandwidth, default fastlock
// R10: 3-bit base ramp rate code table
// R11: ramp rate is base times step factor
// R12: window is (2^L - 1) x 8/3 x 100 ns
// R13: holdover output uses averaged input frequency
// R14: newest 2^D x 2/3 x 100 ns excluded
// R15: step mask blocks increment and decrement requests
// R16: 56-bit step word, seven bytes, lsb first
// R17: reserved input codes make no valid selection
`timescale 1ns/1ps
`include "plhf_cfg.svh"

module plhf_ctrl #(
    parameter int FW = 32,
    parameter int SFW = 8
) (
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  reset_n,
    // byte register port
    input  wire logic [15:0]           reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [7:0]            reg_rdata,
    // device pins and loop status
    input  wire plhf_pkg::plhf_pins_s  pins,
    input  wire logic [SFW-1:0]        ramp_step_factor,
    input  wire logic [FW-1:0]         input_freq,
    // loop steering
    output plhf_pkg::plhf_loop_s       loop_ctrl,
    output logic      [11+SFW:0]       ramp_rate,
    output logic                       ramp_bypass,
    output logic      [55:0]           dco_offset,
    output logic      [FW-1:0]         output_freq,
    output logic                       history_valid
);

    localparam int NP = $bits(plhf_pkg::plhf_pins_s);
    localparam int AW = FW + 32;

    // ==========================================
    // pin synchronisers: a change counts once stages two and three agree
    logic [NP-1:0] s1_q, s2_q, s3_q, filt_q;
    logic [NP-1:0] s1_d, s2_d, s3_d, filt_d;
    plhf_pkg::plhf_pins_s pf, pf_prev_q;

    for (genvar i = 0; i < NP; i++) begin : g_sync
        always_comb begin
            s1_d[i] = pins[i];
            s2_d[i] = s1_q[i];
            s3_d[i] = s2_q[i];
            filt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : filt_q[i];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            filt_q <= '0;
            pf_prev_q <= '0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            filt_q <= filt_d;
            pf_prev_q <= pf;
        end
    end

    assign pf = plhf_pkg::plhf_pins_s'(filt_q);

    // ==========================================
    // configuration registers
    logic [7:0]  step_byte_q [`PLHF_STEP_BYTES];
    logic [7:0]  step_byte_d [`PLHF_STEP_BYTES];
    logic [2:0]  sel_q, sel_d;
    logic        auto_q, auto_d, force_q, force_d;
    logic        ho_en_q, ho_en_d, byp_q, byp_d, exit_q, exit_d;
    logic [2:0]  rate_q, rate_d;
    logic [4:0]  len_q, len_d, dly_q, dly_d;
    logic        mask_q, mask_d;
    logic [7:0]  rdata_q, rdata_d;
    logic [55:0] step_word;

    for (genvar b = 0; b < `PLHF_STEP_BYTES; b++) begin : g_step
        always_comb begin
            step_byte_d[b] = step_byte_q[b];
            if (reg_wr && reg_addr == `PLHF_OFS_STEP_WORD + 16'(b))
                step_byte_d[b] = reg_wdata;
        end
        assign step_word[8*b +: 8] = step_byte_q[b]; // R16
    end

    always_comb begin
        sel_d = sel_q;
        auto_d = auto_q;
        force_d = force_q;
        ho_en_d = ho_en_q;
        byp_d = byp_q;
        exit_d = exit_q;
        rate_d = rate_q;
        len_d = len_q;
        dly_d = dly_q;
        mask_d = mask_q;
        if (reg_wr) begin
            case (reg_addr)
                `PLHF_OFS_INPUT_SEL: sel_d = reg_wdata[2:0]; // R1
                `PLHF_OFS_FASTLOCK: begin
                    auto_d = reg_wdata[`PLHF_FL_AUTO_BIT]; // R3
                    force_d = reg_wdata[`PLHF_FL_FORCE_BIT]; // R4
                end
                `PLHF_OFS_HOLDOVER: begin
                    ho_en_d = reg_wdata[`PLHF_HO_EN_BIT]; // R7
                    byp_d = reg_wdata[`PLHF_HO_BYP_BIT]; // R8
                    exit_d = reg_wdata[`PLHF_HO_EXIT_BIT]; // R9
                    rate_d = reg_wdata[`PLHF_HO_RATE_LSB +: 3]; // R10
                end
                `PLHF_OFS_HIST_LEN: len_d = reg_wdata[4:0]; // R12
                `PLHF_OFS_HIST_DLY: dly_d = reg_wdata[4:0]; // R14
                `PLHF_OFS_STEP_MASK: mask_d = reg_wdata[0]; // R15
                default: ;
            endcase
        end
        // reads answer one cycle later; unmapped and reserved bits read zero
        rdata_d = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `PLHF_OFS_INPUT_SEL: rdata_d = {5'h00, sel_q};
                `PLHF_OFS_FASTLOCK: rdata_d = {6'h00, force_q, auto_q};
                `PLHF_OFS_HOLDOVER: rdata_d = {rate_q, exit_q, byp_q, 2'h0, ho_en_q};
                `PLHF_OFS_HIST_LEN: rdata_d = {3'h0, len_q};
                `PLHF_OFS_HIST_DLY: rdata_d = {3'h0, dly_q};
                `PLHF_OFS_STEP_MASK: rdata_d = {7'h00, mask_q};
                default: begin
                    if (reg_addr >= `PLHF_OFS_STEP_WORD &&
                        reg_addr < `PLHF_OFS_STEP_WORD + 16'(`PLHF_STEP_BYTES))
                        rdata_d = step_byte_q[3'(reg_addr - `PLHF_OFS_STEP_WORD)];
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            for (int b = 0; b < `PLHF_STEP_BYTES; b++) begin
                step_byte_q[b] <= 8'h00;
            end
            sel_q <= `PLHF_RST_INPUT_SEL;
            auto_q <= `PLHF_RST_AUTO;
            force_q <= `PLHF_RST_FORCE;
            ho_en_q <= `PLHF_RST_HO_EN;
            byp_q <= `PLHF_RST_BYP;
            exit_q <= `PLHF_RST_EXIT;
            rate_q <= `PLHF_RST_RATE;
            len_q <= `PLHF_RST_HIST;
            dly_q <= `PLHF_RST_HIST;
            mask_q <= `PLHF_RST_MASK;
            rdata_q <= 8'h00;
        end else begin
            step_byte_q <= step_byte_d;
            sel_q <= sel_d;
            auto_q <= auto_d;
            force_q <= force_d;
            ho_en_q <= ho_en_d;
            byp_q <= byp_d;
            exit_q <= exit_d;
            rate_q <= rate_d;
            len_q <= len_d;
            dly_q <= dly_d;
            mask_q <= mask_d;
            rdata_q <= rdata_d;
        end
    end

    // ==========================================
    // bandwidth state and input choice
    plhf_pkg::plhf_state_e st_q, st_d;
    plhf_pkg::plhf_loop_s  loop_q, loop_d;

    always_comb begin
        st_d = st_q;
        case (st_q)
            plhf_pkg::PLHF_NORMAL: begin
                if (ho_en_q && pf.hold_req)
                    st_d = plhf_pkg::PLHF_HOLD;
                else if (auto_q && pf.loss_of_lock_flag)
                    st_d = plhf_pkg::PLHF_FAST;
            end
            plhf_pkg::PLHF_FAST: begin
                if (ho_en_q && pf.hold_req)
                    st_d = plhf_pkg::PLHF_HOLD;
                else if (!pf.loss_of_lock_flag)
                    st_d = plhf_pkg::PLHF_NORMAL; // R6
            end
            plhf_pkg::PLHF_HOLD: begin
                // leaving holdover settles on the chosen bandwidth
                if (!ho_en_q || !pf.hold_req)
                    st_d = exit_q ? plhf_pkg::PLHF_NORMAL : plhf_pkg::PLHF_FAST; // R9
            end
            default: st_d = plhf_pkg::PLHF_NORMAL;
        endcase
        loop_d.holdover = (st_d == plhf_pkg::PLHF_HOLD);
        loop_d.fast_bw = force_q || (st_d == plhf_pkg::PLHF_FAST); // R4 R5
        if (pf.regctrl) begin
            // codes above three carry no input at all
            loop_d.input_valid = (sel_q <= `PLHF_SEL_MAX_CODE); // R17
            loop_d.input_sel = loop_d.input_valid ? sel_q[1:0] : loop_q.input_sel; // R1
        end else begin
            loop_d.input_valid = 1'b1;
            loop_d.input_sel = pf.sel_pins; // R2
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            st_q <= plhf_pkg::PLHF_NORMAL;
            loop_q <= '0;
        end else begin
            st_q <= st_d;
            loop_q <= loop_d;
        end
    end

    // ==========================================
    // ramp rate and dco stepping
    logic [11:0]       base_rate;
    logic [11+SFW:0]   ramp_q, ramp_d;
    logic [55:0]       ofs_q, ofs_d;

    always_comb begin
        case (rate_q) // R10
            3'h0: base_rate = `PLHF_RATE_0;
            3'h1: base_rate = `PLHF_RATE_1;
            3'h2: base_rate = `PLHF_RATE_2;
            3'h3: base_rate = `PLHF_RATE_3;
            3'h4: base_rate = `PLHF_RATE_4;
            3'h5: base_rate = `PLHF_RATE_5;
            3'h6: base_rate = `PLHF_RATE_6;
            default: base_rate = `PLHF_RATE_7;
        endcase
        ramp_d = base_rate * ramp_step_factor; // R11
        ofs_d = ofs_q;
        // only the rising edge of each request moves the offset
        if (!mask_q && pf.inc_req && !pf_prev_q.inc_req) // R15
            ofs_d = ofs_d + step_word; // R16
        if (!mask_q && pf.dec_req && !pf_prev_q.dec_req) // R15
            ofs_d = ofs_d - step_word; // R16
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ramp_q <= '0;
            ofs_q <= 56'h0000_0000_0000_00;
        end else begin
            ramp_q <= ramp_d;
            ofs_q <= ofs_d;
        end
    end

    // ==========================================
    // holdover history: average over the window, then hold back by the delay
    logic [17:0]   ph_q, ph_d;
    logic          dtick;
    logic [1:0]    wsub_q, wsub_d;
    logic [31:0]   wcnt_q, wcnt_d, win_len, dly_len;
    logic [AW-1:0] acc_q, acc_d, acc_sum;
    logic [FW-1:0] pend_q, pend_d, hfreq_q, hfreq_d, ofreq_q, ofreq_d;
    logic [32:0]   dcnt_q, dcnt_d;
    logic          pend_v_q, pend_v_d, hv_q, hv_d;

    always_comb begin
        // fractional phase gives one delay tick per 2/3 x 100 ns on average
        ph_d = ph_q + 18'(`PLHF_DLY_PHASE_STEP);
        dtick = (ph_d >= 18'(`PLHF_DLY_PHASE_TOP));
        if (dtick)
            ph_d = ph_d - 18'(`PLHF_DLY_PHASE_TOP);
        win_len = (32'h0000_0001 << len_q) - 32'h0000_0001; // R12
        dly_len = 32'h0000_0001 << dly_q; // R14
        wsub_d = wsub_q;
        wcnt_d = wcnt_q;
        acc_d = acc_q;
        acc_sum = acc_q + AW'(input_freq);
        pend_d = pend_q;
        pend_v_d = pend_v_q;
        dcnt_d = dcnt_q;
        hfreq_d = hfreq_q;
        hv_d = hv_q;
        if (dtick) begin
            wsub_d = wsub_q + 2'h1;
            if (wsub_q == 2'(`PLHF_WIN_PER_DLY - 1)) begin
                // one window unit done: take a sample
                if (wcnt_q + 32'h0000_0001 >= win_len) begin
                    acc_d = '0;
                    wcnt_d = 32'h0000_0000;
                    if (!pend_v_q) begin
                        // newest sample counts twice so a steady input averages to itself
                        pend_d = (len_q == 5'h00) ? input_freq :
                            FW'((acc_sum + AW'(input_freq)) >> len_q); // R13
                        pend_v_d = 1'b1;
                        dcnt_d = 33'(dly_len);
                    end
                end else begin
                    acc_d = acc_sum;
                    wcnt_d = wcnt_q + 32'h0000_0001;
                end
            end
            if (pend_v_q) begin
                if (dcnt_q <= 33'h0_0000_0001) begin
                    hfreq_d = pend_q; // R14
                    hv_d = 1'b1;
                    pend_v_d = 1'b0;
                end else begin
                    dcnt_d = dcnt_q - 33'h0_0000_0001;
                end
            end
        end
        // history is frozen while holding so the held value stays put
        if (loop_q.holdover) begin
            wsub_d = wsub_q;
            wcnt_d = wcnt_q;
            acc_d = acc_q;
            pend_d = pend_q;
            pend_v_d = pend_v_q;
            dcnt_d = dcnt_q;
            hfreq_d = hfreq_q;
        end
        ofreq_d = (loop_q.holdover && hv_q) ? hfreq_q : input_freq; // R13
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ph_q <= '0;
            wsub_q <= 2'h0;
            wcnt_q <= 32'h0000_0000;
            acc_q <= '0;
            pend_q <= '0;
            pend_v_q <= 1'b0;
            dcnt_q <= '0;
            hfreq_q <= '0;
            hv_q <= 1'b0;
            ofreq_q <= '0;
        end else begin
            ph_q <= ph_d;
            wsub_q <= wsub_d;
            wcnt_q <= wcnt_d;
            acc_q <= acc_d;
            pend_q <= pend_d;
            pend_v_q <= pend_v_d;
            dcnt_q <= dcnt_d;
            hfreq_q <= hfreq_d;
            hv_q <= hv_d;
            ofreq_q <= ofreq_d;
        end
    end

    // ==========================================
    // outputs, all from flip-flops
    assign reg_rdata = rdata_q;
    assign loop_ctrl = loop_q;
    assign ramp_rate = ramp_q;
    assign ramp_bypass = byp_q; // R8
    assign dco_offset = ofs_q;
    assign output_freq = ofreq_q;
    assign history_valid = hv_q;

endmodule

// ===== verif/plhf_ctrl_properties.sv
// assertion checker for the loop c control block
`timescale 1ns/1ps
`include "plhf_cfg.svh"

module plhf_ctrl_properties #(
    parameter int FW  = 32,
    parameter int SFW = 8
) (
    // clock and reset
    input wire logic                 sys_clk,
    input wire logic                 reset_n,
    // byte register port
    input wire logic [15:0]          reg_addr,
    input wire logic [7:0]           reg_wdata,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [7:0]           reg_rdata,
    // pins and loop status
    input wire plhf_pkg::plhf_pins_s pins,
    input wire logic [SFW-1:0]       ramp_step_factor,
    input wire logic [FW-1:0]        input_freq,
    // loop steering
    input wire plhf_pkg::plhf_loop_s loop_ctrl,
    input wire logic [11+SFW:0]      ramp_rate,
    input wire logic                 ramp_bypass,
    input wire logic [55:0]          dco_offset,
    input wire logic [FW-1:0]        output_freq,
    input wire logic                 history_valid
);
    // ==========================================
    // cycles since the last step or holdover request, saturating so they never wrap
    logic [3:0] step_age_q;
    logic [3:0] hold_age_q;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            step_age_q <= 4'hf;
            hold_age_q <= 4'hf;
        end else begin
            step_age_q <= (pins.inc_req || pins.dec_req) ? 4'h0 : step_age_q + {3'h0, step_age_q != 4'hf};
            hold_age_q <= pins.hold_req ? 4'h0 : hold_age_q + {3'h0, hold_age_q != 4'hf};
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // ==========================================
    // assertions
    a_unmapped_read_zero: assert property (reg_rd && reg_addr == 16'h062d |=> reg_rdata == 8'h00)
        else $error("unmapped read returned nonzero data");
    a_holdover_reserved: assert property (reg_rd && reg_addr == `PLHF_OFS_HOLDOVER |=> reg_rdata[2:1] == 2'h0)
        else $error("holdover reserved bits read nonzero");
    a_history_reserved: assert property (reg_rd && (reg_addr == `PLHF_OFS_HIST_LEN || reg_addr == `PLHF_OFS_HIST_DLY)
        |=> reg_rdata[7:5] == 3'h0)
        else $error("history field upper bits read nonzero");
    a_force_fast_bw: assert property (reg_wr && reg_addr == `PLHF_OFS_FASTLOCK && reg_wdata[1]
        |-> ##2 loop_ctrl.fast_bw)
        else $error("forced fastlock did not select wide bandwidth");
    a_bypass_stable: assert property ((!(reg_wr && reg_addr == `PLHF_OFS_HOLDOVER))[*3] |=> $stable(ramp_bypass))
        else $error("ramp bypass moved without a holdover write");
    a_rate_zero_factor: assert property ((ramp_step_factor == '0)[*2] |=> ramp_rate == '0)
        else $error("ramp rate nonzero with zero factor");
    a_step_needs_req: assert property (step_age_q == 4'hf |-> $stable(dco_offset))
        else $error("dco offset moved without a step request");
    a_hold_needs_req: assert property ($rose(loop_ctrl.holdover) |-> hold_age_q < 4'hc)
        else $error("holdover entered without a request");
    a_hold_freq_frozen: assert property ((loop_ctrl.holdover && history_valid)[*3] |-> $stable(output_freq))
        else $error("holdover output frequency moved");
    a_track_input: assert property ((!history_valid)[*3] |-> output_freq == $past(input_freq))
        else $error("output frequency does not follow input");
endmodule

bind plhf_ctrl plhf_ctrl_properties #(.FW(FW), .SFW(SFW)) i_plhf_ctrl_properties (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins(pins), .ramp_step_factor(ramp_step_factor),
    .input_freq(input_freq), .loop_ctrl(loop_ctrl), .ramp_rate(ramp_rate), .ramp_bypass(ramp_bypass),
    .dco_offset(dco_offset), .output_freq(output_freq), .history_valid(history_valid));

// ===== verif/plhf_ctrl_tb.sv
// self-checking bench for the loop c control block
`timescale 1ns/1ps
`include "plhf_cfg.svh"

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end

module plhf_ctrl_tb;
    // ==========================================
    // signals
    logic                 sys_clk;
    logic                 reset_n;
    logic [15:0]          reg_addr;
    logic [7:0]           reg_wdata;
    logic                 reg_wr;
    logic                 reg_rd;
    logic [7:0]           reg_rdata;
    plhf_pkg::plhf_pins_s pins;
    logic [7:0]           ramp_step_factor;
    logic [31:0]          input_freq;
    plhf_pkg::plhf_loop_s loop_ctrl;
    logic [19:0]          ramp_rate;
    logic                 ramp_bypass;
    logic [55:0]          dco_offset;
    logic [31:0]          output_freq;
    logic                 history_valid;
    int                   mismatches;
    int                   n_tests;
    int                   i;
    logic [11:0]          rate_tab [8];
    logic [55:0]          word;

    plhf_ctrl i_plhf_ctrl (
        .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins(pins), .ramp_step_factor(ramp_step_factor),
        .input_freq(input_freq), .loop_ctrl(loop_ctrl), .ramp_rate(ramp_rate), .ramp_bypass(ramp_bypass),
        .dco_offset(dco_offset), .output_freq(output_freq), .history_valid(history_valid));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // ==========================================
    // tasks
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        `CHK("reg_rdata", e, reg_rdata)
    endtask

    // pins pass a 3-flop filter, so each level is held well past it
    task automatic step(input logic up);
        pins.inc_req = up;
        pins.dec_req = !up;
        tick(4);
        pins.inc_req = 1'b0;
        pins.dec_req = 1'b0;
        tick(8);
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // whole run is near 424 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        close_out();
    end

    // ==========================================
    // tests
    initial begin
        rate_tab = '{`PLHF_RATE_0, `PLHF_RATE_1, `PLHF_RATE_2, `PLHF_RATE_3,
                     `PLHF_RATE_4, `PLHF_RATE_5, `PLHF_RATE_6, `PLHF_RATE_7};
        {reg_addr, reg_wdata, reg_wr, reg_rd, pins} = '0;
        ramp_step_factor = 8'h00;
        input_freq = 32'h1234_5678;
        mismatches = 0;
        n_tests = 0;
        reset_n = 1'b0;
        tick(8);
        reset_n = 1'b1;
        rd(`PLHF_OFS_STEP_MASK, 8'h00);
        for (i = 0; i < 7; i++) rd(`PLHF_OFS_STEP_WORD + 16'(i), 8'h00);
        rd(`PLHF_OFS_INPUT_SEL, 8'h00);
        rd(`PLHF_OFS_FASTLOCK, 8'h00);
        rd(`PLHF_OFS_HOLDOVER, 8'h01);
        rd(`PLHF_OFS_HIST_LEN, 8'h00);
        rd(`PLHF_OFS_HIST_DLY, 8'h00);
        wr(`PLHF_OFS_FASTLOCK, 8'hff);
        rd(`PLHF_OFS_FASTLOCK, 8'h03);
        wr(`PLHF_OFS_HOLDOVER, 8'hff);
        rd(`PLHF_OFS_HOLDOVER, 8'hf9);
        // small history values keep the averaging windows short
        wr(`PLHF_OFS_HIST_LEN, 8'he0);
        rd(`PLHF_OFS_HIST_LEN, 8'h00);
        wr(`PLHF_OFS_HIST_DLY, 8'he0);
        rd(`PLHF_OFS_HIST_DLY, 8'h00);
        wr(`PLHF_OFS_STEP_MASK, 8'hff);
        rd(`PLHF_OFS_STEP_MASK, 8'h01);
        wr(16'h062d, 8'hff);
        rd(16'h062d, 8'h00);
        wr(`PLHF_OFS_STEP_MASK, 8'h00);
        wr(`PLHF_OFS_FASTLOCK, 8'h00);
        wr(`PLHF_OFS_HOLDOVER, 8'h09);
        $display("test registers finished");

        pins.loss_of_lock_flag = 1'b1;
        tick(8);
        `CHK("fast_bw", 1'b0, loop_ctrl.fast_bw)
        wr(`PLHF_OFS_FASTLOCK, 8'h01);
        tick(8);
        `CHK("fast_bw", 1'b1, loop_ctrl.fast_bw)
        pins.loss_of_lock_flag = 1'b0;
        tick(8);
        `CHK("fast_bw", 1'b0, loop_ctrl.fast_bw)
        wr(`PLHF_OFS_FASTLOCK, 8'h02);
        tick(2);
        `CHK("fast_bw", 1'b1, loop_ctrl.fast_bw)
        wr(`PLHF_OFS_FASTLOCK, 8'h00);
        tick(2);
        `CHK("fast_bw", 1'b0, loop_ctrl.fast_bw)
        $display("test fastlock finished");

        pins.regctrl = 1'b1;
        tick(8);
        for (i = 0; i < 4; i++) begin
            wr(`PLHF_OFS_INPUT_SEL, 8'(i));
            tick(3);
            `CHK("input_sel", 2'(i), loop_ctrl.input_sel)
            `CHK("input_valid", 1'b1, loop_ctrl.input_valid)
        end
        wr(`PLHF_OFS_INPUT_SEL, 8'h05);
        tick(3);
        `CHK("input_valid", 1'b0, loop_ctrl.input_valid)
        rd(`PLHF_OFS_INPUT_SEL, 8'h05);
        pins.regctrl = 1'b0;
        pins.sel_pins = 2'h2;
        tick(8);
        `CHK("input_sel", 2'h2, loop_ctrl.input_sel)
        `CHK("input_valid", 1'b1, loop_ctrl.input_valid)
        $display("test input select finished");

        wr(`PLHF_OFS_HOLDOVER, 8'he9);
        tick(3);
        `CHK("ramp_rate", 20'h0_0000, ramp_rate)
        ramp_step_factor = 8'h03;
        for (i = 0; i < 8; i++) begin
            wr(`PLHF_OFS_HOLDOVER, {3'(i), 5'h09});
            tick(3);
            `CHK("ramp_rate", {8'h00, rate_tab[i]} * 20'h0_0003, ramp_rate)
            `CHK("ramp_bypass", 1'b1, ramp_bypass)
        end
        wr(`PLHF_OFS_HOLDOVER, 8'h09);
        $display("test ramp rate finished");

        word = 56'h23_4567_89ab_cdef;
        for (i = 0; i < 7; i++) wr(`PLHF_OFS_STEP_WORD + 16'(i), word[8*i+:8]);
        rd(`PLHF_OFS_STEP_WORD + 16'h0002, 8'hab);
        step(1'b1);
        `CHK("dco_offset", word, dco_offset)
        step(1'b1);
        `CHK("dco_offset", word + word, dco_offset)
        step(1'b0);
        `CHK("dco_offset", word, dco_offset)
        wr(`PLHF_OFS_STEP_MASK, 8'h01);
        step(1'b1);
        step(1'b0);
        `CHK("dco_offset", word, dco_offset)
        wr(`PLHF_OFS_STEP_MASK, 8'h00);
        $display("test dco step finished");

        for (i = 0; i < 400 && history_valid !== 1'b1; i++) tick(1);
        `CHK("history_valid", 1'b1, history_valid)
        pins.loss_of_lock_flag = 1'b1;
        pins.hold_req = 1'b1;
        tick(8);
        `CHK("holdover", 1'b1, loop_ctrl.holdover)
        input_freq = 32'h0bad_0bad;
        tick(4);
        `CHK("output_freq", 32'h1234_5678, output_freq)
        pins.hold_req = 1'b0;
        tick(8);
        `CHK("holdover", 1'b0, loop_ctrl.holdover)
        `CHK("fast_bw", 1'b1, loop_ctrl.fast_bw)
        pins.loss_of_lock_flag = 1'b0;
        tick(8);
        `CHK("fast_bw", 1'b0, loop_ctrl.fast_bw)
        wr(`PLHF_OFS_HOLDOVER, 8'h19);
        pins.loss_of_lock_flag = 1'b1;
        pins.hold_req = 1'b1;
        tick(8);
        pins.hold_req = 1'b0;
        tick(8);
        `CHK("fast_bw", 1'b0, loop_ctrl.fast_bw)
        wr(`PLHF_OFS_HOLDOVER, 8'h08);
        pins.hold_req = 1'b1;
        tick(8);
        `CHK("holdover", 1'b0, loop_ctrl.holdover)
        pins.hold_req = 1'b0;
        pins.loss_of_lock_flag = 1'b0;
        tick(8);
        wr(`PLHF_OFS_HIST_LEN, 8'h02);
        wr(`PLHF_OFS_HOLDOVER, 8'h09);
        input_freq = 32'h0000_0300;
        tick(80);
        pins.hold_req = 1'b1;
        tick(8);
        `CHK("output_freq", 32'h0000_0300, output_freq)
        $display("test holdover finished");
        close_out();
    end
endmodule
